// ==== pscr_regs.sv ====
// Notes on behaviour
// - ref source bit: 0 crystal, 1 pin
// - feedback source bit: 0 oscillator, 1 post divider
// - each shutdown bit 1 powers section down
// - output mode bit: 0 PECL, 1 CMOS
// - sync enable bit on sync-capable variant only
// - sync polarity: 0 falling, 1 rising edge
// - pump current and loop resistor 2-bit codes
// - loop capacitor bit: 0 185pF, 1 500pF
// - post divider a modulus is code plus one
// - post divider b modulus is code plus one
// - post divider c modulus 1, 2, 4, 8
// - reference length 12 bits, bits 0 to 11
// - feedback length 14 bits, bits 24 to 37
// - clear at power-up, read back as written
// - byte updates on its acknowledge, not stop
`timescale 1ns/1ps
`default_nettype none

`include "pscr_defines.svh"

module pscr_regs
    import pscr_pkg::*;
#(
    parameter bit SYNC_CAPABLE = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,

    // byte access from the serial engine
    input wire pscr_wr_t byte_wr,
    input wire pscr_rd_t byte_rd,
    output logic [7:0] rd_data_r,
    output logic rd_valid_r,

    // end-of-cycle pulses from the divider counters
    input wire logic ref_cycle_end,
    input wire logic fbk_cycle_end,
    input wire logic post_cycle_end,

    // static analog controls
    output wire pscr_ctrl_t ctrl_r,

    // divider settings applied to the counters
    output var pscr_div_t div_r
);

    logic [7:0] byte_r [8];
    logic [63:0] cfg_word;
    logic [3:0] post_a_code;
    logic [3:0] post_b_code;
    logic [1:0] post_c_code;

    // eight byte registers, each written on its own acknowledge
    for (genvar i = 0; i < 8; i++) begin : g_byte
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                byte_r[i] <= `PSCR_RST_BYTE;
            end else if (byte_wr.ack && byte_wr.addr == 3'(i)) begin
                // no wait for stop: a partly written burst is live at once
                byte_r[i] <= byte_wr.data;
            end
        end
        // byte i carries word bits 8i to 8i+7
        assign cfg_word[8*i +: 8] = byte_r[i];
    end

    // read port: reserved bits come back as stored, whatever the host wrote
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r <= byte_r[byte_rd.addr];
            rd_valid_r <= byte_rd.req;
        end
    end

    // static controls are flop bits of the bank, visible right after the write
    assign ctrl_r.ref_source_select = cfg_word[`PSCR_REF_SRC_BIT];
    assign ctrl_r.feedback_source_select = cfg_word[`PSCR_FBK_SRC_BIT];
    assign ctrl_r.power_down_a = cfg_word[`PSCR_PD_A_BIT];
    assign ctrl_r.power_down_b = cfg_word[`PSCR_PD_B_BIT];
    assign ctrl_r.cmos_output_mode = cfg_word[`PSCR_CMOS_BIT];

    // a part without the sync input never sees sync enabled
    assign ctrl_r.sync_enable_bit = cfg_word[`PSCR_SYNC_EN_BIT] & SYNC_CAPABLE;
    assign ctrl_r.sync_edge_polarity = cfg_word[`PSCR_SYNC_POL_BIT] & SYNC_CAPABLE;

    // loop tuning codes passed to the analog loop filter
    assign ctrl_r.pump_current_select = cfg_word[`PSCR_PUMP_MSB:`PSCR_PUMP_LSB];
    assign ctrl_r.loop_resistor_select = cfg_word[`PSCR_RES_MSB:`PSCR_RES_LSB];
    assign ctrl_r.loop_capacitor_select = cfg_word[`PSCR_CAP_BIT];

    // post divider codes as stored
    assign post_a_code = cfg_word[`PSCR_POST_A_MSB:`PSCR_POST_A_LSB];
    assign post_b_code = cfg_word[`PSCR_POST_B_MSB:`PSCR_POST_B_LSB];
    assign post_c_code = cfg_word[`PSCR_POST_C_MSB:`PSCR_POST_C_LSB];

    // divider settings load only at a cycle boundary, so no runt count appears;
    // a forbidden post code keeps the previous modulus instead of a guess
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else begin
            if (ref_cycle_end) begin
                div_r.reference_divider_length <=
                    cfg_word[`PSCR_REF_LEN_MSB:`PSCR_REF_LEN_LSB];
            end
            if (fbk_cycle_end) begin
                div_r.feedback_divider_length <=
                    cfg_word[`PSCR_FBK_LEN_MSB:`PSCR_FBK_LEN_LSB];
            end
            if (post_cycle_end) begin
                if (post_a_code <= `PSCR_POST_MAX_CODE) begin
                    div_r.post_divider_a_modulus <= post_a_code + 4'h1;
                end
                if (post_b_code <= `PSCR_POST_MAX_CODE) begin
                    div_r.post_divider_b_modulus <= post_b_code + 4'h1;
                end
                div_r.post_divider_c_modulus <= 4'h1 << post_c_code;
            end
        end
    end

    // checks on the bank and the applied settings
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // bytes written since reset; an untouched byte must still read as cleared
    logic [7:0] wr_seen_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_seen_r <= 8'h00;
        end else if (byte_wr.ack) begin
            wr_seen_r[byte_wr.addr] <= 1'b1;
        end
    end

    // write and read ports
    AST_WRITE_ON_ACK:
    assert property (byte_wr.ack |=> byte_r[$past(byte_wr.addr)] == $past(byte_wr.data))
    else $error("byte not updated on its acknowledge");

    AST_READ_BACK:
    assert property (byte_rd.req && !byte_wr.ack
                     |=> rd_valid_r && rd_data_r == byte_r[$past(byte_rd.addr)])
    else $error("read data differs from stored byte");

    // each control byte reaches its fields the cycle after its acknowledge
    AST_SOURCE_SELECTS:
    assert property (byte_wr.ack && byte_wr.addr == `PSCR_OFS_REF_HI_CTRL
                     |=> ctrl_r.ref_source_select == $past(byte_wr.data[4])
                         && ctrl_r.power_down_a == $past(byte_wr.data[5]))
    else $error("reference source or shutdown a wrong after write");

    AST_FEEDBACK_OUTPUT:
    assert property (byte_wr.ack && byte_wr.addr == `PSCR_OFS_FBK_HI_OUT
                     |=> ctrl_r.feedback_source_select == $past(byte_wr.data[6])
                         && ctrl_r.cmos_output_mode == $past(byte_wr.data[7]))
    else $error("feedback source or output mode wrong after write");

    AST_SHUT_SYNC:
    assert property (byte_wr.ack && byte_wr.addr == `PSCR_OFS_SHUT_SYNC
                     |=> ctrl_r.power_down_b == $past(byte_wr.data[5])
                         && ctrl_r.sync_enable_bit == ($past(byte_wr.data[0]) & SYNC_CAPABLE)
                         && ctrl_r.sync_edge_polarity == ($past(byte_wr.data[1]) & SYNC_CAPABLE))
    else $error("shutdown b or sync controls wrong after write");

    AST_LOOP_TUNING:
    assert property (byte_wr.ack && byte_wr.addr == `PSCR_OFS_LOOP_TUNING
                     |=> ctrl_r.pump_current_select == $past(byte_wr.data[1:0])
                         && ctrl_r.loop_resistor_select == $past(byte_wr.data[5:4])
                         && ctrl_r.loop_capacitor_select == $past(byte_wr.data[6]))
    else $error("loop tuning controls wrong after write");

    // post divider moduli, legal and forbidden codes
    AST_POST_A_MODULUS:
    assert property (post_cycle_end && post_a_code <= 4'hb
                     |=> div_r.post_divider_a_modulus == $past(post_a_code) + 4'h1)
    else $error("post divider a modulus not code plus one");

    AST_POST_B_FORBIDDEN:
    assert property (post_cycle_end && post_b_code > 4'hb
                     |=> $stable(div_r.post_divider_b_modulus))
    else $error("forbidden post divider b code was applied");

    AST_POST_C_MODULUS:
    assert property (post_cycle_end && post_c_code == 2'h3
                     |=> div_r.post_divider_c_modulus == 4'h8)
    else $error("post divider c code 3 not modulus 8");

    // lengths load only at their own boundary
    AST_REF_LENGTH:
    assert property (ref_cycle_end |=> div_r.reference_divider_length == $past(cfg_word[11:0]))
    else $error("reference length not loaded at cycle end");

    AST_FBK_LENGTH:
    assert property (fbk_cycle_end |=> div_r.feedback_divider_length == $past(cfg_word[37:24]))
    else $error("feedback length not loaded at cycle end");

    AST_HOLD_MID_CYCLE:
    assert property (!fbk_cycle_end && !ref_cycle_end
                     |=> $stable(div_r.feedback_divider_length)
                         && $stable(div_r.reference_divider_length))
    else $error("divider length changed inside a divider cycle");

    // reset view: the disable is lifted so the held-reset state itself is checked
    AST_RESET_CLEAR:
    assert property (@(posedge mclk) disable iff (1'b0)
                     !rst_n |-> cfg_word == 64'h0 && div_r == '0 && !rd_valid_r && rd_data_r == 8'h00)
    else $error("bank not cleared while reset is held");

    // first edge after release: nothing can have been written or applied yet
    AST_RESET_RELEASE:
    assert property (@(posedge mclk) disable iff (1'b0)
                     $rose(rst_n) |-> cfg_word == 64'h0 && div_r == '0)
    else $error("bank not clear at the first edge after reset");

    // the read answer is one cycle wide and comes for every request
    AST_READ_ANSWER:
    assert property (byte_rd.req |=> rd_valid_r)
    else $error("read request not answered in the next cycle");

    AST_READ_VALID_PULSE:
    assert property (!byte_rd.req |=> !rd_valid_r)
    else $error("read valid without a request");

    AST_UNWRITTEN_ZERO:
    assert property (byte_rd.req && !wr_seen_r[byte_rd.addr] |=> rd_data_r == 8'h00)
    else $error("untouched byte does not read as cleared");

    // a byte moves only on its own acknowledge
    for (genvar k = 0; k < 8; k++) begin : g_byte_chk
        AST_BYTE_HOLD:
        assert property (@(posedge mclk) disable iff (!rst_n)
                         !(byte_wr.ack && byte_wr.addr == 3'(k)) |=> $stable(byte_r[k]))
        else $error("byte changed without its acknowledge");
    end

    AST_CTRL_HOLD:
    assert property (!byte_wr.ack |=> $stable(ctrl_r))
    else $error("static controls moved without a byte write");

    // every control field sits on its assigned byte and bit, checked against the bytes directly
    AST_CTRL_MAP:
    assert property (ctrl_r.ref_source_select == byte_r[1][4]
                     && ctrl_r.power_down_a == byte_r[1][5]
                     && ctrl_r.feedback_source_select == byte_r[4][6]
                     && ctrl_r.cmos_output_mode == byte_r[4][7]
                     && ctrl_r.power_down_b == byte_r[6][5]
                     && ctrl_r.loop_capacitor_select == byte_r[5][6])
    else $error("control field not on its byte position");

    AST_SYNC_MAP:
    assert property (ctrl_r.sync_edge_polarity == (byte_r[6][1] & SYNC_CAPABLE)
                     && ctrl_r.sync_enable_bit == (byte_r[6][0] & SYNC_CAPABLE))
    else $error("sync controls not on byte six bits zero and one");

    AST_TUNING_MAP:
    assert property (ctrl_r.pump_current_select == byte_r[5][1:0]
                     && ctrl_r.loop_resistor_select == byte_r[5][5:4])
    else $error("loop tuning codes not on byte five");

    // the split feedback byte lands on word bits 32 to 39
    AST_WORD_MAP:
    assert property (byte_wr.ack && byte_wr.addr == `PSCR_OFS_FBK_HI_OUT
                     |=> cfg_word[39:32] == $past(byte_wr.data))
    else $error("byte four not mapped to word bits 32 to 39");

    // applied settings traced straight from the byte registers, not through the word
    AST_REF_FROM_BYTES:
    assert property (ref_cycle_end
                     |=> div_r.reference_divider_length == {$past(byte_r[1][3:0]), $past(byte_r[0])})
    else $error("reference length not taken from bytes zero and one");

    AST_FBK_FROM_BYTES:
    assert property (fbk_cycle_end
                     |=> div_r.feedback_divider_length == {$past(byte_r[4][5:0]), $past(byte_r[3])})
    else $error("feedback length not taken from bytes three and four");

    AST_POST_FROM_BYTE2:
    assert property (post_cycle_end && byte_r[2][3:0] <= 4'hb && byte_r[2][7:4] <= 4'hb
                     |=> div_r.post_divider_a_modulus == $past(byte_r[2][3:0]) + 4'h1
                         && div_r.post_divider_b_modulus == $past(byte_r[2][7:4]) + 4'h1)
    else $error("post divider codes not taken from byte two");

    AST_POST_B_MODULUS:
    assert property (post_cycle_end && post_b_code <= 4'hb
                     |=> div_r.post_divider_b_modulus == $past(post_b_code) + 4'h1)
    else $error("post divider b modulus not code plus one");

    AST_POST_A_FORBIDDEN:
    assert property (post_cycle_end && post_a_code > 4'hb
                     |=> $stable(div_r.post_divider_a_modulus))
    else $error("forbidden post divider a code was applied");

    // the third post divider is a power of two for every code
    AST_POST_C_ONE:
    assert property (post_cycle_end && post_c_code == 2'h0 |=> div_r.post_divider_c_modulus == 4'h1)
    else $error("post divider c code 0 not modulus 1");

    AST_POST_C_TWO:
    assert property (post_cycle_end && post_c_code == 2'h1 |=> div_r.post_divider_c_modulus == 4'h2)
    else $error("post divider c code 1 not modulus 2");

    AST_POST_C_FOUR:
    assert property (post_cycle_end && post_c_code == 2'h2 |=> div_r.post_divider_c_modulus == 4'h4)
    else $error("post divider c code 2 not modulus 4");

    // each divider holds its setting until its own boundary, whatever the others do
    AST_REF_HOLD:
    assert property (!ref_cycle_end |=> $stable(div_r.reference_divider_length))
    else $error("reference length changed inside its cycle");

    AST_FBK_HOLD:
    assert property (!fbk_cycle_end |=> $stable(div_r.feedback_divider_length))
    else $error("feedback length changed inside its cycle");

    AST_POST_HOLD:
    assert property (!post_cycle_end
                     |=> $stable(div_r.post_divider_a_modulus)
                         && $stable(div_r.post_divider_b_modulus)
                         && $stable(div_r.post_divider_c_modulus))
    else $error("post divider modulus changed inside its cycle");

    // main scenarios
    COV_BURST_WRITE:
    cover property (byte_wr.ack ##1 byte_wr.ack ##1 byte_wr.ack);

    COV_WRITE_THEN_APPLY:
    cover property (byte_wr.ack && byte_wr.addr == `PSCR_OFS_FBK_LO ##[1:20] fbk_cycle_end);

    COV_FORBIDDEN_POST:
    cover property (post_cycle_end && post_a_code > 4'hb);

    COV_READ_AFTER_WRITE:
    cover property (byte_wr.ack ##1 byte_rd.req ##1 rd_valid_r);

    COV_READ_RESERVED:
    cover property (byte_rd.req && byte_rd.addr == `PSCR_OFS_RSVD_TOP ##1 rd_valid_r);

endmodule : pscr_regs

`default_nettype wire

// ==== pscr_defines.svh ====
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH

// byte offsets of the configuration bank
`define PSCR_OFS_REF_LO 3'h0
`define PSCR_OFS_REF_HI_CTRL 3'h1
`define PSCR_OFS_POST_MODULI 3'h2
`define PSCR_OFS_FBK_LO 3'h3
`define PSCR_OFS_FBK_HI_OUT 3'h4
`define PSCR_OFS_LOOP_TUNING 3'h5
`define PSCR_OFS_SHUT_SYNC 3'h6
`define PSCR_OFS_RSVD_TOP 3'h7

// field positions within the 64-bit configuration word
`define PSCR_REF_LEN_LSB 0
`define PSCR_REF_LEN_MSB 11
`define PSCR_REF_SRC_BIT 12
`define PSCR_PD_A_BIT 13
`define PSCR_POST_C_LSB 14
`define PSCR_POST_C_MSB 15
`define PSCR_POST_A_LSB 16
`define PSCR_POST_A_MSB 19
`define PSCR_POST_B_LSB 20
`define PSCR_POST_B_MSB 23
`define PSCR_FBK_LEN_LSB 24
`define PSCR_FBK_LEN_MSB 37
`define PSCR_FBK_SRC_BIT 38
`define PSCR_CMOS_BIT 39
`define PSCR_PUMP_LSB 40
`define PSCR_PUMP_MSB 41
`define PSCR_RES_LSB 44
`define PSCR_RES_MSB 45
`define PSCR_CAP_BIT 46
`define PSCR_SYNC_EN_BIT 48
`define PSCR_SYNC_POL_BIT 49
`define PSCR_PD_B_BIT 53

// reset value and post divider limit
`define PSCR_RST_BYTE 8'h00
`define PSCR_POST_MAX_CODE 4'hb

`endif

// ==== pscr_pkg.sv ====
package pscr_pkg;

    // one byte write, issued when the serial engine acknowledges it
    typedef struct packed {
        logic ack;
        logic [2:0] addr;
        logic [7:0] data;
    } pscr_wr_t;

    // one byte read request
    typedef struct packed {
        logic req;
        logic [2:0] addr;
    } pscr_rd_t;

    // static controls for the analog sections
    typedef struct packed {
        logic ref_source_select;
        logic feedback_source_select;
        logic power_down_a;
        logic power_down_b;
        logic cmos_output_mode;
        logic sync_enable_bit;
        logic sync_edge_polarity;
        logic [1:0] pump_current_select;
        logic [1:0] loop_resistor_select;
        logic loop_capacitor_select;
    } pscr_ctrl_t;

    // divider settings as applied to the counters
    typedef struct packed {
        logic [11:0] reference_divider_length;
        logic [13:0] feedback_divider_length;
        logic [3:0] post_divider_a_modulus;
        logic [3:0] post_divider_b_modulus;
        logic [3:0] post_divider_c_modulus;
    } pscr_div_t;

endpackage : pscr_pkg

// ==== pscr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pscr_host_model
    import pscr_pkg::*;
(
    // clock
    input wire logic mclk,

    // byte access toward the bank
    output var pscr_wr_t byte_wr,
    output var pscr_rd_t byte_rd,
    input wire logic [7:0] rd_data_r,
    input wire logic rd_valid_r
);
    // writable bits of each byte, byte 7 on top; reserved places go out as zero
    localparam logic [63:0] KEEP = 64'h0023_73ff_ffff_ffff;

    // idle bus at time zero
    initial begin
        byte_wr = '0;
        byte_rd = '0;
    end

    // one acknowledged byte; address and data are scrambled once ack drops
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        byte_wr = '{ack: 1'b1, addr: a, data: d & KEEP[a*8 +: 8]};
        @(negedge mclk);
        byte_wr = '{ack: 1'b0, addr: ~a, data: ~byte_wr.data};
    endtask : wr

    // read request, then a bounded wait for the answer
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        bit got;
        got = 1'b0;
        d = 'x;
        @(negedge mclk);
        byte_rd = '{req: 1'b1, addr: a};
        @(negedge mclk);
        byte_rd = '{req: 1'b0, addr: ~a};
        for (int i = 0; i < 3 && !got; i++) begin
            if (rd_valid_r === 1'b1) begin
                d = rd_data_r;
                got = 1'b1;
            end else begin
                @(negedge mclk);
            end
        end
    endtask : rd
endmodule : pscr_host_model

`default_nettype wire

// ==== tb_pscr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_pscr_regs;
    import pscr_pkg::*;
    logic mclk, rst_n, ref_end, fbk_end, post_end;
    pscr_wr_t byte_wr;
    pscr_rd_t byte_rd;
    logic [7:0] rd_data_r, rb;
    logic rd_valid_r;
    pscr_ctrl_t ctrl_r;
    pscr_div_t div_r;
    int n_errors = 0;
    int cmp_count = 0;
    // two full images, byte 7 on top, with the control and divider views they imply
    logic [63:0] rows [2] = '{64'h0023_52ff_34ab_bbff, 64'h0002_2160_0000_6001};
    logic [12:0] ectl [2] = '{13'b1111111_10_01_1, 13'b0110001_01_10_0};
    logic [37:0] ediv [2] = '{{12'hbff, 14'h3f34, 4'hc, 4'hb, 4'h4}, {12'h001, 14'h2000, 4'h1, 4'h1, 4'h2}};

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    pscr_regs u_pscr_regs (
        .mclk(mclk), .rst_n(rst_n), .byte_wr(byte_wr), .byte_rd(byte_rd),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .ref_cycle_end(ref_end),
        .fbk_cycle_end(fbk_end), .post_cycle_end(post_end), .ctrl_r(ctrl_r), .div_r(div_r)
    );

    pscr_host_model u_pscr_host_model (
        .mclk(mclk), .byte_wr(byte_wr), .byte_rd(byte_rd),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r)
    );

    // compare and count
    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // one-cycle divider boundary pulses; the applied value settles a cycle later
    task automatic pulse(input logic [2:0] p);
        @(negedge mclk);
        {ref_end, fbk_end, post_end} = p;
        @(negedge mclk);
        {ref_end, fbk_end, post_end} = 3'b000;
        @(negedge mclk);
    endtask : pulse

    // watchdog, far beyond the some 175 cycles the sequence needs
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        {ref_end, fbk_end, post_end} = 3'b000;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        check("ctrl reset", ctrl_r, 64'h0);
        check("div reset", div_r, 64'h0);
        for (int a = 0; a < 8; a++) begin
            u_pscr_host_model.rd(a[2:0], rb);
            check("byte reset", rb, 64'h0);
        end
        // the read answer stands for one cycle only
        @(negedge mclk);
        check("valid drop", rd_valid_r, 64'h0);
        // whole image written with no stop; controls follow each ack, dividers wait
        for (int r = 0; r < 2; r++) begin
            for (int a = 0; a < 8; a++) begin
                u_pscr_host_model.wr(a[2:0], rows[r][a*8 +: 8]);
            end
            check("ctrl", ctrl_r, ectl[r]);
            check("div held", div_r, (r == 0) ? 38'h0 : ediv[0]);
            pulse(3'b111);
            check("div", div_r, ediv[r]);
            for (int a = 0; a < 8; a++) begin
                u_pscr_host_model.rd(a[2:0], rb);
                check("byte", rb, rows[r][a*8 +: 8]);
            end
        end
        // every legal post divider code; only the post boundary pulses
        for (int c = 0; c < 12; c++) begin
            u_pscr_host_model.wr(3'h2, {c[3:0], c[3:0]});
            u_pscr_host_model.wr(3'h1, {c[1:0], 6'h00});
            pulse(3'b001);
            check("post a", div_r.post_divider_a_modulus, c + 1);
            check("post b", div_r.post_divider_b_modulus, c + 1);
            check("post c", div_r.post_divider_c_modulus, 4'h1 << c[1:0]);
        end
        report_and_stop();
    end
endmodule : tb_pscr_regs

`default_nettype wire
